// ===== design/pmr_defs.svh
// Purpose: Constants of the power-manager serial register bank
// Assumes: Included by both ends of the serial link
// Notes:   Reset values follow the power-up defaults
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH
// ----------------------------------------
// Slave addresses
// ----------------------------------------
`define PMR_ADDR_WR    8'h9C
`define PMR_ADDR_RD    8'h9D
// ----------------------------------------
// Command opcodes and reset values
// ----------------------------------------
`define PMR_OP_AUXEN   3'h1
`define PMR_OP_AUXV    3'h2
`define PMR_OP_CORE    3'h3
`define PMR_RST_GRP    3'h0
`define PMR_RST_AUXEN  2'h3
`define PMR_RST_AUXV   5'h1B
`define PMR_RST_CORE   5'h0E
`define PMR_RST_MAIN   6'h3F
`define PMR_RST_MASK   6'h3F
`define PMR_RST_STAT   8'h40
`define PMR_MASK_RSV   2
// ----------------------------------------
// Controller register offsets (bytes)
// ----------------------------------------
`define PMR_REG_CMD    5'h00
`define PMR_REG_DATA   5'h04
`define PMR_REG_STAT   5'h08
`define PMR_REG_IST    5'h0C
`define PMR_REG_IMSK   5'h10
`define PMR_RST_IMSK   3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define PMR_CLK_NS     10
`define PMR_QTR_NS     250
`define PMR_QTR_CYC    ((`PMR_QTR_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)
`endif

// ===== design/pmr_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes:   One-hot state codes
package pmr_pkg;
   typedef enum logic [4:0] {
      DS_IDLE = 5'h01,
      DS_RX   = 5'h02,
      DS_ACK  = 5'h04,
      DS_TX   = 5'h08,
      DS_TACK = 5'h10
   } pmr_dst_t;
   typedef enum logic [3:0] {
      HS_IDLE  = 4'h1,
      HS_START = 4'h2,
      HS_BIT   = 4'h4,
      HS_STOP  = 4'h8
   } pmr_hst_t;
endpackage

// ===== design/pmr_if.sv
// Purpose: Two-wire serial link with open-drain resolution
// Assumes: Pull-ups on both lines
// Notes:   A line is low while any enabled driver drives low
`timescale 1ns/1ps
interface pmr_if;
   logic scl;
   logic sda;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic irq_out_n;
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport dev  (input scl, sda, output dev_sda_o, dev_sda_oe, irq_out_n);
   modport host (input scl, sda, irq_out_n,
                 output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface

// ===== design/pmr_dev.sv
// Purpose: Serial slave and command register bank of the power manager
// Assumes: Bus lines and event inputs are asynchronous to clk
// Notes:   Registers take their defaults under rst
//
// Overview of operation
// - Idle bus leaves data and clock high
// - Detect start and stop while clock high
// - Receiver pulls data low in ack pulse
// - Master nacks last read byte; release data
// - Accept unlimited bytes between start and stop
// - Answer write address 9C, then commands
// - Master sends one or two commands
// - Upper bits zero select register group
// - Bits 2:1 select aux four voltage
// - Bits 4:3 select aux five voltage
// - Command 011 sets core feedback code when group is not zero
// - Read address 9D returns interrupt status
// - Unmasked event lowers interrupt until read
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_dev (
   input  wire logic       clk,
   input  wire logic       rst,
   pmr_if.dev              bus,
   input  wire logic       adapter_input,
   input  wire logic       adapter_identify,
   input  wire logic       charge_timeout,
   input  wire logic       charge_complete,
   output logic            aux_linear_reg_five_en,
   output logic            aux_linear_reg_four_en,
   output logic [1:0]      aux5_volt_sel,
   output logic [1:0]      aux4_volt_sel,
   output logic            charger_en,
   output logic [4:0]      voltage_program_field,
   output logic [4:0]      main_enables,
   output logic            sleep_enable_pin_mask,
   output logic [5:0]      event_masks
);
   import pmr_pkg::*;
   // ----------------------------------------
   // Line synchronisers and conditions
   // ----------------------------------------
   logic [1:0] scl_sy_q;
   logic [1:0] sda_sy_q;
   logic       scl_p_q;
   logic       sda_p_q;
   wire        scl_s = scl_sy_q[1];
   wire        sda_s = sda_sy_q[1];
   wire        start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire        stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire        rise_w  = scl_s & ~scl_p_q;
   wire        fall_w  = ~scl_s & scl_p_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sy_q <= 2'h3;
         sda_sy_q <= 2'h3;
         scl_p_q  <= 1'b1;
         sda_p_q  <= 1'b1;
      end else begin
         scl_sy_q <= {scl_sy_q[0], bus.scl};
         sda_sy_q <= {sda_sy_q[0], bus.sda};
         scl_p_q  <= scl_s;
         sda_p_q  <= sda_s;
      end
   end
   // ----------------------------------------
   // Event synchronisers and edges
   // ----------------------------------------
   logic [3:0] ev_m_q;
   logic [3:0] ev_s_q;
   logic [3:0] ev_p_q;
   wire        in_rise_w = ev_s_q[0] & ~ev_p_q[0];
   wire        in_fall_w = ~ev_s_q[0] & ev_p_q[0];
   wire        id_now_w  = ev_s_q[0] & ev_s_q[1];
   wire        id_was_w  = ev_p_q[0] & ev_p_q[1];
   wire [7:0]  ev_set_w  = {in_rise_w, in_fall_w, id_now_w & ~id_was_w, 1'b0,
                            ev_s_q[2] & ~ev_p_q[2], ev_s_q[3] & ~ev_p_q[3], 2'h0};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ev_m_q <= 4'h0;
         ev_s_q <= 4'h0;
         ev_p_q <= 4'h0;
      end else begin
         ev_m_q <= {charge_complete, charge_timeout, adapter_identify, adapter_input};
         ev_s_q <= ev_m_q;
         ev_p_q <= ev_s_q;
      end
   end
   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   pmr_dst_t   st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic       oe_q;
   logic       addr_q;
   logic       rd_q;
   logic       more_q;
   logic       zero_q;
   logic [7:0] stat_q;
   wire        byte_w  = fall_w & (cnt_q == 4'h8);
   wire        cmd_w   = (st_q == DS_RX) & byte_w & ~addr_q;
   wire        load_w  = fall_w & (((st_q == DS_ACK) & rd_q) |
                                   ((st_q == DS_TACK) & more_q));
   wire        clr_w   = (st_q == DS_TACK) & rise_w;
   wire        wr_hit  = sh_q == `PMR_ADDR_WR;
   wire        rd_hit  = sh_q == `PMR_ADDR_RD;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= DS_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 8'h00;
         oe_q   <= 1'b0;
         addr_q <= 1'b0;
         rd_q   <= 1'b0;
         more_q <= 1'b0;
      end else if (stop_w) begin
         st_q <= DS_IDLE;
         oe_q <= 1'b0;
      end else if (start_w) begin
         st_q   <= DS_RX;
         addr_q <= 1'b1;
         cnt_q  <= 4'h0;
         oe_q   <= 1'b0;
      end else if (load_w) begin
         sh_q  <= stat_q;
         oe_q  <= ~stat_q[7];
         cnt_q <= 4'h1;
         st_q  <= DS_TX;
      end else begin
         case (st_q)
            DS_RX: begin
               if (rise_w && cnt_q < 4'h8) begin
                  sh_q  <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               if (byte_w) begin
                  if (!addr_q || wr_hit || rd_hit) begin
                     oe_q <= 1'b1;
                     st_q <= DS_ACK;
                  end else begin
                     st_q <= DS_IDLE;
                  end
                  if (addr_q) begin
                     rd_q <= rd_hit;
                  end
               end
            end
            DS_ACK: begin
               if (fall_w) begin
                  oe_q   <= 1'b0;
                  addr_q <= 1'b0;
                  cnt_q  <= 4'h0;
                  st_q   <= DS_RX;
               end
            end
            DS_TX: begin
               if (fall_w) begin
                  if (cnt_q == 4'h8) begin
                     oe_q <= 1'b0;
                     st_q <= DS_TACK;
                  end else begin
                     sh_q  <= {sh_q[6:0], 1'b0};
                     oe_q  <= ~sh_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            DS_TACK: begin
               if (rise_w) begin
                  more_q <= ~sda_s;
               end
               if (fall_w) begin
                  st_q <= DS_IDLE;
               end
            end
            default: begin
               oe_q <= 1'b0;
            end
         endcase
      end
   end
   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic [2:0] grp_q;
   logic [1:0] auxen_q;
   logic [4:0] auxv_q;
   logic [4:0] core_q;
   logic [5:0] main_q;
   logic [5:0] mask_q;
   wire [2:0]  op_w   = sh_q[7:5];
   wire        g0_w   = grp_q == 3'h0;
   wire        sel_w  = cmd_w & (sh_q[7:3] == 5'h00);
   wire        cmd2_w = cmd_w & ~sel_w;
   wire        wr_e1  = cmd2_w & g0_w & ~sh_q[7];
   wire        wr_e2  = cmd2_w & g0_w & (sh_q[7:6] == 2'h2);
   wire        wr_d1  = cmd2_w & ~g0_w & (op_w == `PMR_OP_AUXEN);
   wire        wr_d2  = cmd2_w & ~g0_w & (op_w == `PMR_OP_AUXV);
   wire        wr_d3  = cmd2_w & ~g0_w & (op_w == `PMR_OP_CORE);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grp_q   <= `PMR_RST_GRP;
         auxen_q <= `PMR_RST_AUXEN;
         auxv_q  <= `PMR_RST_AUXV;
         core_q  <= `PMR_RST_CORE;
         main_q  <= `PMR_RST_MAIN;
         mask_q  <= `PMR_RST_MASK;
      end else begin
         if (sel_w) begin
            grp_q <= sh_q[2:0];
         end
         if (wr_d1) begin
            auxen_q <= sh_q[4:3];
         end
         if (wr_d2) begin
            auxv_q <= {sh_q[4:1], sh_q[0]};
         end
         if (wr_d3) begin
            core_q <= sh_q[4:0];
         end
         if (wr_e1) begin
            main_q <= sh_q[5:0];
         end
         if (wr_e2) begin
            mask_q <= sh_q[5:0] | 6'h04;
         end
      end
   end
   // ----------------------------------------
   // Interrupt status and output
   // ----------------------------------------
   logic       irq_n_q;
   wire [4:0]  pend_w = {stat_q[7:5], stat_q[3:2]} &
                        ~{mask_q[5:3], mask_q[1:0]};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q  <= `PMR_RST_STAT;
         irq_n_q <= 1'b1;
         zero_q  <= 1'b0;
      end else begin
         stat_q  <= (clr_w ? 8'h00 : stat_q) | ev_set_w;
         irq_n_q <= ~|pend_w;
         zero_q  <= 1'b0;
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign bus.dev_sda_o           = zero_q;
   assign bus.dev_sda_oe          = oe_q;
   assign bus.irq_out_n           = irq_n_q;
   assign aux_linear_reg_five_en  = auxen_q[1];
   assign aux_linear_reg_four_en  = auxen_q[0];
   assign aux5_volt_sel           = auxv_q[4:3];
   assign aux4_volt_sel           = auxv_q[2:1];
   assign charger_en              = auxv_q[0];
   assign voltage_program_field   = core_q;
   assign main_enables            = main_q[5:1];
   assign sleep_enable_pin_mask   = main_q[0];
   assign event_masks             = mask_q;
endmodule

// ===== design/pmr_host.sv
// Purpose: Serial bus master driven from an Avalon-MM register set
// Assumes: Device interrupt line asynchronous to clk
// Notes:   Makes the serial clock by a divider
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_host #(
   parameter int QTR = `PMR_QTR_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   pmr_if.host              bus,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq
);
   import pmr_pkg::*;
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [1:0] sda_sy_q;
   logic [1:0] irq_sy_q;
   logic       irq_p_q;
   wire        sda_s = sda_sy_q[1];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_sy_q <= 2'h3;
         irq_sy_q <= 2'h3;
         irq_p_q  <= 1'b1;
      end else begin
         sda_sy_q <= {sda_sy_q[0], bus.sda};
         irq_sy_q <= {irq_sy_q[0], bus.irq_out_n};
         irq_p_q  <= irq_sy_q[1];
      end
   end
   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   pmr_hst_t   st_q;
   logic       wr_q;
   logic [31:0] rdat_q;
   logic [15:0] data_q;
   logic [7:0] rx_q;
   logic       nack_q;
   logic [2:0] ist_q;
   logic [2:0] imsk_q;
   logic       irq_q;
   logic       done_w;
   wire        req_w  = avs_read | avs_write;
   wire        take_w = req_w & ~wr_q;
   wire        a_cmd  = avs_address == `PMR_REG_CMD;
   wire        a_data = avs_address == `PMR_REG_DATA;
   wire        a_stat = avs_address == `PMR_REG_STAT;
   wire        a_ist  = avs_address == `PMR_REG_IST;
   wire        a_imsk = avs_address == `PMR_REG_IMSK;
   wire        go_w   = take_w & avs_write & a_cmd & (st_q == HS_IDLE) &
                        (avs_writedata[1:0] != 2'h0);
   wire [31:0] rmux_w = a_data ? {16'h0000, data_q} :
                        a_stat ? {16'h0000, rx_q, 5'h00, ~irq_sy_q[1], nack_q,
                                  st_q != HS_IDLE} :
                        a_ist  ? {29'h0, ist_q} :
                        a_imsk ? {29'h0, imsk_q} : 32'h0;
   wire [2:0]  iset_w = {irq_p_q & ~irq_sy_q[1], done_w & nack_q, done_w};
   wire        iclr_w = take_w & avs_read & a_ist;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q   <= 1'b1;
         rdat_q <= 32'h0;
         data_q <= 16'h0;
         ist_q  <= 3'h0;
         imsk_q <= `PMR_RST_IMSK;
         irq_q  <= 1'b0;
      end else begin
         wr_q <= ~(req_w & wr_q);
         if (req_w & wr_q) begin
            rdat_q <= rmux_w;
         end
         if (take_w & avs_write & a_data) begin
            data_q <= avs_writedata[15:0];
         end
         if (take_w & avs_write & a_imsk) begin
            imsk_q <= avs_writedata[2:0];
         end
         // Clear only the bits handed out, so an event in the wait cycle survives
         ist_q <= (iclr_w ? ist_q & ~rdat_q[2:0] : ist_q) | iset_w;
         irq_q <= |(ist_q & ~imsk_q);
      end
   end
   // ----------------------------------------
   // Serial engine
   // ----------------------------------------
   logic [$clog2(QTR)-1:0] div_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [1:0] bi_q;
   logic [1:0] nb_q;
   logic       rd_q;
   logic       scl_oe_q;
   logic       sda_oe_q;
   logic       zero_q;
   wire        tick_w = div_q == ($clog2(QTR))'(QTR - 1);
   wire        recv_w = rd_q & (bi_q == 2'h1);
   wire [7:0]  byte_w = (bi_q == 2'h0) ? (rd_q ? `PMR_ADDR_RD : `PMR_ADDR_WR) :
                        (bi_q == 2'h1) ? data_q[7:0] : data_q[15:8];
   wire        last_w = nack_q | (bi_q + 2'h1 == nb_q);
   assign done_w = (st_q == HS_STOP) & tick_w & (ph_q == 2'h3);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= HS_IDLE;
         div_q <= '0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         bi_q <= 2'h0;
         nb_q <= 2'h0;
         rd_q <= 1'b0;
         nack_q <= 1'b0;
         rx_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (go_w) begin
         st_q <= HS_START;
         div_q <= '0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         bi_q <= 2'h0;
         rd_q <= avs_writedata[1:0] == 2'h3;
         nb_q <= (avs_writedata[1:0] == 2'h2) ? 2'h3 : 2'h2;
         nack_q <= 1'b0;
      end else if (st_q != HS_IDLE) begin
         div_q <= tick_w ? '0 : div_q + 1'b1;
         if (tick_w) begin
            ph_q <= ph_q + 2'h1;
            case (st_q)
               HS_START: begin
                  if (ph_q == 2'h1) begin
                     sda_oe_q <= 1'b1;
                  end
                  if (ph_q == 2'h3) begin
                     scl_oe_q <= 1'b1;
                     st_q <= HS_BIT;
                  end
               end
               HS_BIT: begin
                  if (ph_q == 2'h0) begin
                     sda_oe_q <= ~bit_q[3] & ~recv_w & ~byte_w[~bit_q[2:0]];
                  end
                  if (ph_q == 2'h1) begin
                     scl_oe_q <= 1'b0;
                  end
                  if (ph_q == 2'h2 && !bit_q[3] && recv_w) begin
                     rx_q <= {rx_q[6:0], sda_s};
                  end
                  if (ph_q == 2'h2 && bit_q[3] && !recv_w && sda_s) begin
                     nack_q <= 1'b1;
                  end
                  if (ph_q == 2'h3) begin
                     scl_oe_q <= 1'b1;
                     bit_q <= bit_q[3] ? 4'h0 : bit_q + 4'h1;
                     if (bit_q[3]) begin
                        bi_q <= bi_q + 2'h1;
                        st_q <= last_w ? HS_STOP : HS_BIT;
                     end
                  end
               end
               HS_STOP: begin
                  if (ph_q == 2'h0) begin
                     sda_oe_q <= 1'b1;
                  end
                  if (ph_q == 2'h1) begin
                     scl_oe_q <= 1'b0;
                  end
                  if (ph_q == 2'h2) begin
                     sda_oe_q <= 1'b0;
                  end
                  if (ph_q == 2'h3) begin
                     st_q <= HS_IDLE;
                  end
               end
               default: begin
                  st_q <= HS_IDLE;
               end
            endcase
         end
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign bus.host_scl_o  = zero_q;
   assign bus.host_scl_oe = scl_oe_q;
   assign bus.host_sda_o  = zero_q;
   assign bus.host_sda_oe = sda_oe_q;
   assign avs_readdata    = rdat_q;
   assign avs_waitrequest = wr_q;
   assign irq             = irq_q;
endmodule

// ===== testbench/pmr_props.sv
// Purpose: Assertions on the serial link between the two ends
// Assumes: Lines are sampled directly by clk
// Notes:   Bit position is rebuilt from the lines
`timescale 1ns/1ps
module pmr_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe,
   input wire logic irq_out_n
);
   // ----------------------------------------
   // Link tracking
   // ----------------------------------------
   logic       scl_q, sda_q, busy_q, first_q, rd_q;
   logic [3:0] bitn_q;
   logic [7:0] byte_q;
   wire        rise_w  = scl & ~scl_q;
   wire        start_w = scl & scl_q & ~sda & sda_q;
   wire        stop_w  = scl & scl_q & sda & ~sda_q;
   wire        ack_w   = rise_w & (bitn_q == 4'h8);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q   <= 1'h1;
         sda_q   <= 1'h1;
         busy_q  <= 1'h0;
         first_q <= 1'h0;
         rd_q    <= 1'h0;
         bitn_q  <= 4'h0;
         byte_q  <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_w) begin
            busy_q  <= 1'h1;
            first_q <= 1'h1;
            bitn_q  <= 4'h0;
         end else if (stop_w) begin
            busy_q <= 1'h0;
         end else if (rise_w) begin
            bitn_q  <= ack_w ? 4'h0 : bitn_q + 4'h1;
            byte_q  <= ack_w ? byte_q : {byte_q[6:0], sda};
            first_q <= first_q & ~ack_w;
            rd_q    <= (ack_w & first_q) ? byte_q[0] : rd_q;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_idle_high:
      assert property (!busy_q && !start_w |-> scl && sda && !dev_sda_oe)
      else $error("link not released while idle");
   a_start_clock:
      assert property (start_w |-> ##[1:40] !scl)
      else $error("no clock after start");
   a_addr_ack:
      assert property (ack_w && first_q && byte_q[7:1] == 7'h4E |-> !sda)
      else $error("address not acknowledged");
   a_cmd_ack:
      assert property (ack_w && busy_q && !first_q && !rd_q |-> !sda)
      else $error("command byte not acknowledged");
   a_rx_quiet:
      assert property (rise_w && busy_q && bitn_q < 4'h8 && (first_q || !rd_q) |-> !dev_sda_oe)
      else $error("device drives while receiving");
   a_dev_stable:
      assert property (scl |=> !scl || $stable(dev_sda_oe))
      else $error("device data moved while clock high");
   a_read_release:
      assert property (ack_w && !first_q && rd_q |-> !dev_sda_oe)
      else $error("device holds data in master ack bit");
   a_irq_release:
      assert property (ack_w && !first_q && rd_q |-> ##[1:12] irq_out_n)
      else $error("interrupt not released after read");
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench of host and device joined by the link
// Assumes: Host quarter bit cut to 8 clocks
// Notes:   Device commands go only through the host registers; its event inputs are driven directly
`timescale 1ns/1ps
`include "pmr_defs.svh"
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) begin \
         errors++; \
         $display("wrong value %s exp %0h got %0h", nm, ex, got); \
      end \
   end
module tb;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clk              = 1'h0;
   logic        rst              = 1'h1;
   logic [4:0]  avs_address      = 5'h00;
   logic        avs_read         = 1'h0;
   logic        avs_write        = 1'h0;
   logic [31:0] avs_writedata    = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        adapter_input    = 1'h0;
   logic        adapter_identify = 1'h0;
   logic        charge_timeout   = 1'h0;
   logic        charge_complete  = 1'h0;
   logic        aux_linear_reg_five_en;
   logic        aux_linear_reg_four_en;
   logic [1:0]  aux5_volt_sel;
   logic [1:0]  aux4_volt_sel;
   logic        charger_en;
   logic [4:0]  voltage_program_field;
   logic [4:0]  main_enables;
   logic        sleep_enable_pin_mask;
   logic [5:0]  event_masks;
   int          errors           = 0;
   int          cmp_count        = 0;
   logic [4:0]  codes [4]        = '{5'h00, 5'h0F, 5'h10, 5'h1F};
   pmr_if bus_if ();
   always #5 clk = ~clk;
   pmr_dev u_pmr_dev (.clk, .rst, .bus(bus_if), .adapter_input, .adapter_identify,
      .charge_timeout, .charge_complete, .aux_linear_reg_five_en, .aux_linear_reg_four_en,
      .aux5_volt_sel, .aux4_volt_sel, .charger_en, .voltage_program_field, .main_enables,
      .sleep_enable_pin_mask, .event_masks);
   pmr_host #(.QTR(8)) u_pmr_host (.clk, .rst, .bus(bus_if), .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
   pmr_props u_pmr_props (.clk(clk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
      .dev_sda_oe(bus_if.dev_sda_oe), .irq_out_n(bus_if.irq_out_n));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      q = avs_readdata;
      if (avs_waitrequest !== 1'h0) errors++;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      av(1'h0, a, 32'h0, q);
   endtask
   task automatic send(input logic [1:0] op, input logic [7:0] c0, input logic [7:0] c1);
      logic [31:0] q;
      int          n;
      av(1'h1, `PMR_REG_DATA, {16'h0, c1, c0}, q);
      av(1'h1, `PMR_REG_CMD, {30'h0, op}, q);
      q = 32'h0;
      n = 0;
      while (q[0] !== 1'h1 && n < 1000) begin
         rd(`PMR_REG_IST, q);
         n++;
      end
      `CHK("done", 2'h1, q[1:0])
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #500us;
      errors++;
      end_of_test;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      `CHK("aux_en", 2'h3, {aux_linear_reg_five_en, aux_linear_reg_four_en})
      `CHK("aux_sel", 4'hD, {aux5_volt_sel, aux4_volt_sel})
      `CHK("charger", 1'h1, charger_en)
      `CHK("core", 5'h0E, voltage_program_field)
      `CHK("main", 6'h3F, {main_enables, sleep_enable_pin_mask})
      `CHK("masks", 6'h3F, event_masks)
      `CHK("irq_n", 1'h1, bus_if.irq_out_n)
      rd(`PMR_REG_IMSK, q);
      `CHK("imsk", 32'h7, q)
      av(1'h1, 5'h14, 32'hFFFFFFFF, q);
      rd(5'h14, q);
      `CHK("unmapped", 32'h0, q)
      av(1'h1, `PMR_REG_CMD, 32'h0, q);
      rd(`PMR_REG_STAT, q);
      `CHK("busy", 1'h0, q[0])
      $display("test defaults done");
      send(2'h2, 8'h2A, 8'h80);
      `CHK("main", 6'h2A, {main_enables, sleep_enable_pin_mask})
      `CHK("masks", 6'h04, event_masks)
      send(2'h2, 8'h01, 8'h28);
      `CHK("aux_en", 2'h1, {aux_linear_reg_five_en, aux_linear_reg_four_en})
      `CHK("main", 6'h2A, {main_enables, sleep_enable_pin_mask})
      $display("test group zero done");
      for (int i = 0; i < 4; i++) begin
         send(2'h1, {3'h2, i[1:0], ~i[1:0], i[0]}, 8'h00);
         `CHK("volt", {i[1:0], ~i[1:0], i[0]}, {aux5_volt_sel, aux4_volt_sel, charger_en})
      end
      foreach (codes[k]) begin
         send(2'h1, {3'h3, codes[k]}, 8'h00);
         `CHK("core", codes[k], voltage_program_field)
      end
      send(2'h2, 8'h00, 8'h9F);
      `CHK("masks", 6'h1F, event_masks)
      $display("test voltages done");
      av(1'h1, `PMR_REG_IMSK, 32'h3, q);
      adapter_input <= 1'h1;
      repeat (20) @(posedge clk);
      `CHK("irq_n", 1'h0, bus_if.irq_out_n)
      `CHK("irq", 1'h1, irq)
      rd(`PMR_REG_STAT, q);
      `CHK("stat", 3'h4, q[2:0])
      rd(`PMR_REG_IST, q);
      `CHK("ist", 3'h4, q[2:0])
      repeat (2) @(posedge clk);
      `CHK("irq", 1'h0, irq)
      send(2'h3, 8'h00, 8'h00);
      rd(`PMR_REG_STAT, q);
      `CHK("status", 8'hC0, q[15:8])
      repeat (20) @(posedge clk);
      `CHK("irq_n", 1'h1, bus_if.irq_out_n)
      adapter_identify <= 1'h1;
      charge_timeout   <= 1'h1;
      charge_complete  <= 1'h1;
      repeat (20) @(posedge clk);
      `CHK("irq_n", 1'h1, bus_if.irq_out_n)
      send(2'h3, 8'h00, 8'h00);
      rd(`PMR_REG_STAT, q);
      `CHK("status", 8'h2C, q[15:8])
      $display("test interrupts done");
      end_of_test;
   end
endmodule
